// file: ev_pkg.sv
package ev_pkg;

  // Clock and start-up timeout
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int STARTUP_TIMEOUT_MS = 1;
  localparam int STARTUP_CYCLES    =
    STARTUP_TIMEOUT_MS * 1000000000 / CLK_PERIOD_PS;

  // Register word indices, byte address is four times the index
  localparam logic [7:0] IDX_SWRST   = 8'h1F;
  localparam logic [7:0] IDX_SUMMARY = 8'h20;
  localparam logic [7:0] IDX_RST     = 8'h21;
  localparam logic [7:0] IDX_BUCK    = 8'h22;
  localparam logic [7:0] IDX_BOOST   = 8'h23;
  localparam logic [7:0] IDX_MON     = 8'h24;
  localparam logic [7:0] IDX_LIVE    = 8'h25;
  localparam logic [7:0] IDX_MBUCK   = 8'h30;
  localparam logic [7:0] IDX_MBOOST  = 8'h31;
  localparam logic [7:0] IDX_MMON    = 8'h32;
  localparam logic [7:0] IDX_MRST    = 8'h33;

  // Value loaded into every mask register at the reset-event reload
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Event bits of each group, the rest are plain storage
  localparam logic [7:0] BUCK_EVT  = 8'h77;
  localparam logic [7:0] BOOST_EVT = 8'h07;
  localparam logic [7:0] MON_EVT   = 8'h15;
  localparam logic [7:0] RST_EVT   = 8'h01;

  // Field positions
  localparam int BUCK_A_OVERCURRENT = 0;
  localparam int BUCK_A_SHORT       = 1;
  localparam int BUCK_A_POWERGOOD   = 2;
  localparam int BUCK_B_OVERCURRENT = 4;
  localparam int BUCK_B_SHORT       = 5;
  localparam int BUCK_B_POWERGOOD   = 6;
  localparam int BOOST_OVERCURRENT  = 0;
  localparam int BOOST_SHORT        = 1;
  localparam int BOOST_POWERGOOD    = 2;
  localparam int ANALOG_POWERGOOD   = 0;
  localparam int MONITOR_A_PG       = 2;
  localparam int MONITOR_B_PG       = 4;
  localparam int RESET_EVENT        = 0;
  localparam int SUM_BUCK           = 4;
  localparam int SUM_BOOST          = 5;
  localparam int SUM_MONITOR        = 6;
  localparam int LIVE_OVERVOLTAGE   = 0;
  localparam int LIVE_THERMAL_WARN  = 1;
  localparam int LIVE_THERMAL_SD    = 2;
  localparam int LIVE_CLOCK_INVALID = 3;
  localparam int SWRST_BIT          = 0;

  // Positions in the synchronised input vector
  localparam int IN_UV    = 0;
  localparam int IN_BPG   = 1;
  localparam int IN_BEN   = 3;
  localparam int IN_BLOW  = 5;
  localparam int IN_BOC   = 7;
  localparam int IN_XPG   = 9;
  localparam int IN_XEN   = 10;
  localparam int IN_XLOW  = 11;
  localparam int IN_XOC   = 12;
  localparam int IN_MPG   = 13;
  localparam int IN_APG   = 15;
  localparam int IN_CLK   = 16;
  localparam int IN_TSD   = 17;
  localparam int IN_TWARN = 18;
  localparam int IN_OVP   = 19;
  localparam int IN_COUNT = 20;

  // Reset-event sequencer states
  typedef enum logic [1:0] {
    RS_IDLE  = 2'b00,
    RS_SHUT  = 2'b01,
    RS_LOAD  = 2'b10,
    RS_START = 2'b11
  } rst_st_t;

endpackage

// file: pmic_fault_event_latches.sv
`timescale 1ns/1ps
module pmic_fault_event_latches #(
  parameter int STARTUP_CYCLES = ev_pkg::STARTUP_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Analog detector levels
  input  wire logic        analog_supply_low,
  input  wire logic [1:0]  buck_pg_event,
  input  wire logic [1:0]  buck_enable,
  input  wire logic [1:0]  buck_below_min,
  input  wire logic [1:0]  buck_overcurrent,
  input  wire logic        boost_pg_event,
  input  wire logic        boost_enable,
  input  wire logic        boost_below_min,
  input  wire logic        boost_overcurrent,
  input  wire logic [1:0]  monitor_pg_event,
  input  wire logic        analog_supply_pg_event,
  input  wire logic        clock_invalid,
  input  wire logic        thermal_shutdown_status,
  input  wire logic        thermal_warning_status,
  input  wire logic        input_overvoltage_status,
  // Interrupt and power sequencing
  output logic             irq,
  output logic             converters_off,
  output logic             startup_go
);

  localparam int NIN = ev_pkg::IN_COUNT;
  localparam int TW  = $clog2(STARTUP_CYCLES + 1);

  typedef struct packed {
    logic [NIN-1:0]     s1;
    logic [NIN-1:0]     s2;
    logic [NIN-1:0]     s3;
    logic [NIN-1:0]     flt;
    logic [2:0]         run;
    logic [2:0][TW-1:0] tmr;
    logic [7:0]         buck;
    logic [7:0]         boost;
    logic [7:0]         mon;
    logic [7:0]         rstf;
    logic [7:0]         mbuck;
    logic [7:0]         mboost;
    logic [7:0]         mmon;
    logic [7:0]         mrst;
    ev_pkg::rst_st_t    st;
    logic               off;
    logic               go;
    logic               dph;
    logic               wt;
    logic               dwr;
    logic               dok;
    logic [7:0]         didx;
    logic [31:0]        rdata;
  } state_t;

  state_t         r;
  state_t         n;
  logic [NIN-1:0] rise;
  logic [2:0]     en;
  logic [2:0]     below;
  logic [2:0]     short;
  logic [2:0]     tmo;
  logic [7:0]     wd;
  logic [7:0]     buck_set;
  logic [7:0]     boost_set;
  logic [7:0]     mon_set;
  logic [7:0]     rst_set;
  logic [7:0]     summary;
  logic [7:0]     live;
  logic           act;
  logic           wr;
  logic           rd;
  logic           take;
  logic           swrst;
  logic           trig;
  logic           buck_any;

  // Write-one-to-clear on event bits, set beats clear, rest is storage
  function automatic logic [7:0] w1c(input logic [7:0] old,
                                     input logic [7:0] set,
                                     input logic       we,
                                     input logic [7:0] d,
                                     input logic [7:0] evt);
    logic [7:0] clr;
    clr = we ? (d & evt) : 8'h00;
    w1c = (((old & ~clr) | set) & evt) | ((we ? d : old) & ~evt);
  endfunction

  // Bus phase decode
  assign take  = hsel & htrans[1] & hready;
  assign act   = r.dph & ~r.wt;
  assign wr    = act & r.dwr & r.dok;
  assign rd    = act & ~r.dwr;
  assign wd    = hwdata[7:0];
  assign swrst = wr && (r.didx == ev_pkg::IDX_SWRST) &&
                 wd[ev_pkg::SWRST_BIT];

  // A filtered rising level is one event
  assign rise  = r.s2 & r.s3 & ~r.flt;
  assign trig  = rise[ev_pkg::IN_UV] | swrst;
  assign en    = {r.flt[ev_pkg::IN_XEN], r.flt[ev_pkg::IN_BEN+1],
                  r.flt[ev_pkg::IN_BEN]};
  assign below = {r.flt[ev_pkg::IN_XLOW], r.flt[ev_pkg::IN_BLOW+1],
                  r.flt[ev_pkg::IN_BLOW]};
  assign buck_any = |(r.buck & ev_pkg::BUCK_EVT);

  // Event set vectors and readable summaries
  always_comb begin
    buck_set  = 8'h00;
    boost_set = 8'h00;
    mon_set   = 8'h00;
    rst_set   = 8'h00;
    summary   = 8'h00;
    live      = 8'h00;
    buck_set[ev_pkg::BUCK_A_POWERGOOD]   = rise[ev_pkg::IN_BPG];
    buck_set[ev_pkg::BUCK_B_POWERGOOD]   = rise[ev_pkg::IN_BPG+1];
    buck_set[ev_pkg::BUCK_A_SHORT]       = short[0];
    buck_set[ev_pkg::BUCK_B_SHORT]       = short[1];
    buck_set[ev_pkg::BUCK_A_OVERCURRENT] = rise[ev_pkg::IN_BOC];
    buck_set[ev_pkg::BUCK_B_OVERCURRENT] = rise[ev_pkg::IN_BOC+1];
    boost_set[ev_pkg::BOOST_POWERGOOD]   = rise[ev_pkg::IN_XPG];
    boost_set[ev_pkg::BOOST_SHORT]       = short[2];
    boost_set[ev_pkg::BOOST_OVERCURRENT] = rise[ev_pkg::IN_XOC];
    mon_set[ev_pkg::MONITOR_A_PG]        = rise[ev_pkg::IN_MPG];
    mon_set[ev_pkg::MONITOR_B_PG]        = rise[ev_pkg::IN_MPG+1];
    mon_set[ev_pkg::ANALOG_POWERGOOD]    = rise[ev_pkg::IN_APG];
    rst_set[ev_pkg::RESET_EVENT]         = trig;
    summary[ev_pkg::SUM_BUCK]    = buck_any;
    summary[ev_pkg::SUM_BOOST]   = |(r.boost & ev_pkg::BOOST_EVT);
    summary[ev_pkg::SUM_MONITOR] = |(r.mon & ev_pkg::MON_EVT);
    live[ev_pkg::LIVE_CLOCK_INVALID] = r.flt[ev_pkg::IN_CLK];
    live[ev_pkg::LIVE_THERMAL_SD]    = r.flt[ev_pkg::IN_TSD];
    live[ev_pkg::LIVE_THERMAL_WARN]  = r.flt[ev_pkg::IN_TWARN];
    live[ev_pkg::LIVE_OVERVOLTAGE]   = r.flt[ev_pkg::IN_OVP];
  end

  // Next-state logic for the whole block
  always_comb begin
    n = r;
    // Synchroniser, a change counts once stages two and three agree
    n.s1  = {input_overvoltage_status, thermal_warning_status,
             thermal_shutdown_status, clock_invalid,
             analog_supply_pg_event, monitor_pg_event,
             boost_overcurrent, boost_below_min, boost_enable,
             boost_pg_event, buck_overcurrent, buck_below_min,
             buck_enable, buck_pg_event, analog_supply_low};
    n.s2  = r.s1;
    n.s3  = r.s2;
    n.flt = (r.s2 & r.s3) | (r.flt & (r.s2 | r.s3));

    for (int i = 0; i < 3; i++) begin
      tmo[i] = 1'b0;
      if (!en[i]) begin
        n.run[i] = 1'b0;
        n.tmr[i] = '0;
      end else if (!r.run[i]) begin
        if (!below[i]) begin
          n.run[i] = 1'b1;
        end else if (r.tmr[i] == TW'(STARTUP_CYCLES - 1)) begin
          tmo[i]   = 1'b1;
          n.run[i] = 1'b1;
        end else begin
          n.tmr[i] = r.tmr[i] + 1'b1;
        end
      end
      short[i] = (r.run[i] & en[i] & below[i]) | tmo[i];
    end

    // AHB-Lite: one wait state, write or read done in it
    if (act) begin
      n.wt = 1'b1;
    end else begin
      n.dph = take;
      n.wt  = 1'b0;
      if (take) begin
        n.dwr  = hwrite;
        n.didx = haddr[9:2];
        n.dok  = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
      end
    end
    if (rd) begin
      n.rdata = 32'h0000_0000;
      if (r.dok) begin
        case (r.didx)
          ev_pkg::IDX_SUMMARY: n.rdata = 32'(summary);
          ev_pkg::IDX_RST:     n.rdata = 32'(r.rstf);
          ev_pkg::IDX_BUCK:    n.rdata = 32'(r.buck);
          ev_pkg::IDX_BOOST:   n.rdata = 32'(r.boost);
          ev_pkg::IDX_MON:     n.rdata = 32'(r.mon);
          ev_pkg::IDX_LIVE:    n.rdata = 32'(live);
          ev_pkg::IDX_MBUCK:   n.rdata = 32'(r.mbuck);
          ev_pkg::IDX_MBOOST:  n.rdata = 32'(r.mboost);
          ev_pkg::IDX_MMON:    n.rdata = 32'(r.mmon);
          ev_pkg::IDX_MRST:    n.rdata = 32'(r.mrst);
          default:             n.rdata = 32'h0000_0000;
        endcase
      end
    end

    // sticky flags, cleared by writing one
    n.rstf  = w1c(r.rstf, rst_set, wr && r.didx == ev_pkg::IDX_RST,
                  wd, ev_pkg::RST_EVT);
    n.buck  = w1c(r.buck, buck_set, wr && r.didx == ev_pkg::IDX_BUCK,
                  wd, ev_pkg::BUCK_EVT);
    n.boost = w1c(r.boost, boost_set,
                  wr && r.didx == ev_pkg::IDX_BOOST, wd,
                  ev_pkg::BOOST_EVT);
    n.mon   = w1c(r.mon, mon_set, wr && r.didx == ev_pkg::IDX_MON,
                  wd, ev_pkg::MON_EVT);

    // Interrupt mask registers, one blocks the bit
    if (wr && r.didx == ev_pkg::IDX_MBUCK) n.mbuck = wd & ev_pkg::BUCK_EVT;
    if (wr && r.didx == ev_pkg::IDX_MBOOST) begin
      n.mboost = wd & ev_pkg::BOOST_EVT;
    end
    if (wr && r.didx == ev_pkg::IDX_MMON) n.mmon = wd & ev_pkg::MON_EVT;
    if (wr && r.didx == ev_pkg::IDX_MRST) n.mrst = wd & ev_pkg::RST_EVT;

    // register reload, events in this cycle still latch
    if (r.st == ev_pkg::RS_LOAD) begin
      n.buck   = buck_set & ev_pkg::BUCK_EVT;
      n.boost  = boost_set & ev_pkg::BOOST_EVT;
      n.mon    = mon_set & ev_pkg::MON_EVT;
      n.rstf   = r.rstf | rst_set;
      n.mbuck  = ev_pkg::FLAGS_RESET;
      n.mboost = ev_pkg::FLAGS_RESET;
      n.mmon   = ev_pkg::FLAGS_RESET;
      n.mrst   = ev_pkg::FLAGS_RESET;
    end

    case (r.st)
      ev_pkg::RS_IDLE:  if (trig) n.st = ev_pkg::RS_SHUT;
      ev_pkg::RS_SHUT:  n.st = ev_pkg::RS_LOAD;
      ev_pkg::RS_LOAD:  n.st = ev_pkg::RS_START;
      ev_pkg::RS_START: n.st = ev_pkg::RS_IDLE;
      default:          n.st = ev_pkg::RS_IDLE;
    endcase
    n.off = (n.st == ev_pkg::RS_SHUT) || (n.st == ev_pkg::RS_LOAD);
    n.go  = (n.st == ev_pkg::RS_START);
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outputs
  assign hrdata         = r.rdata;
  assign hreadyout      = ~act;
  assign hresp          = 1'b0;
  assign converters_off = r.off;
  assign startup_go     = r.go;
  assign irq = |(r.buck & ~r.mbuck & ev_pkg::BUCK_EVT) |
               |(r.boost & ~r.mboost & ev_pkg::BOOST_EVT) |
               |(r.mon & ~r.mmon & ev_pkg::MON_EVT) |
               |(r.rstf & ~r.mrst & ev_pkg::RST_EVT);

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence seq_off;
    converters_off [*2];
  endsequence

  sequence seq_go;
    (startup_go && !converters_off) ##1 !startup_go;
  endsequence

  AST_RESET_LATCH: assert property (trig |=> r.rstf[0])
    else $error("Reset flag not latched");
  AST_RESET_SEQUENCE: assert property (
      (r.st == ev_pkg::RS_IDLE && trig) |=> seq_off ##1 seq_go)
    else $error("Reset sequence wrong");
  AST_RESET_KEEP: assert property (
      (wr && r.didx == ev_pkg::IDX_RST && !wd[0] && r.rstf[0])
      |=> r.rstf[0])
    else $error("Reset flag lost on zero write");
  AST_BUCK_PG: assert property (
      rise[ev_pkg::IN_BPG] |=> r.buck[ev_pkg::BUCK_A_POWERGOOD])
    else $error("Buck power-good not latched");
  AST_BUCK_SHORT: assert property (
      (r.run[0] && en[0] && below[0]) |=> r.buck[ev_pkg::BUCK_A_SHORT])
    else $error("Buck short not latched");
  AST_BUCK_TIMEOUT: assert property (
      tmo[1] |=> r.buck[ev_pkg::BUCK_B_SHORT] && r.run[1])
    else $error("Buck start-up timeout not latched");
  AST_BUCK_ILIM: assert property (
      rise[ev_pkg::IN_BOC+1] |=> r.buck[ev_pkg::BUCK_B_OVERCURRENT])
    else $error("Buck current limit not latched");
  AST_BOOST_PG: assert property (
      rise[ev_pkg::IN_XPG] |=> r.boost[ev_pkg::BOOST_POWERGOOD])
    else $error("Boost power-good not latched");
  AST_BOOST_SHORT: assert property (
      (r.run[2] && en[2] && below[2]) |=> r.boost[ev_pkg::BOOST_SHORT])
    else $error("Boost short not latched");
  AST_BOOST_TIMEOUT: assert property (
      tmo[2] |=> r.boost[ev_pkg::BOOST_SHORT])
    else $error("Boost start-up timeout not latched");
  AST_BOOST_ILIM: assert property (
      rise[ev_pkg::IN_XOC] |=> r.boost[ev_pkg::BOOST_OVERCURRENT])
    else $error("Boost current limit not latched");
  AST_MON_PG: assert property (
      rise[ev_pkg::IN_MPG+1] |=> r.mon[ev_pkg::MONITOR_B_PG])
    else $error("Monitor power-good not latched");
  AST_ANA_PG: assert property (
      rise[ev_pkg::IN_APG] |=> r.mon[ev_pkg::ANALOG_POWERGOOD])
    else $error("Analog power-good not latched");
  AST_BUCK_CLEAR: assert property (
      (wr && r.didx == ev_pkg::IDX_BUCK && wd[0] &&
       !rise[ev_pkg::IN_BOC]) |=> !r.buck[0])
    else $error("Buck flag not cleared by one");
  AST_SUMMARY: assert property (
      (rd && r.dok && r.didx == ev_pkg::IDX_SUMMARY)
      |=> hrdata[ev_pkg::SUM_BUCK] == $past(buck_any))
    else $error("Buck summary wrong");
  AST_LIVE_CLOCK: assert property (
      (rd && r.dok && r.didx == ev_pkg::IDX_LIVE)
      |=> hrdata[ev_pkg::LIVE_CLOCK_INVALID] ==
          $past(r.flt[ev_pkg::IN_CLK]))
    else $error("Clock status wrong");
  AST_FLAG_HOLD: assert property (
      (r.buck[6] && r.st != ev_pkg::RS_LOAD &&
       !(wr && r.didx == ev_pkg::IDX_BUCK && wd[6])) |=> r.buck[6])
    else $error("Buck flag dropped");

endmodule // pmic_fault_event_latches

// file: pmic_fault_event_latches_bench.sv
`timescale 1ns/1ps
module pmic_fault_event_latches_bench;
  // Clock, reset and bus
  logic        clk;
  logic        resetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  // Detector levels and sequencing outputs
  logic        supply_low;
  logic [8:0]  ev;
  logic [2:0]  en;
  logic [2:0]  low;
  logic [3:0]  live_in;
  logic        irq;
  logic        conv_off;
  logic        go;
  // Bookkeeping
  int          failures;
  int          cmp_count;
  int          off_cnt;
  int          go_cnt;
  int          dp_edges;
  logic [31:0] rd;

  // Short start-up count keeps the run brief
  localparam int SC = 20;
  // Event inputs: target register and bit of each
  localparam logic [7:0] EV_REG [9] = '{ev_pkg::IDX_BUCK, ev_pkg::IDX_BUCK,
    ev_pkg::IDX_BUCK, ev_pkg::IDX_BUCK, ev_pkg::IDX_BOOST, ev_pkg::IDX_BOOST,
    ev_pkg::IDX_MON, ev_pkg::IDX_MON, ev_pkg::IDX_MON};
  localparam int EV_BIT [9] = '{2, 6, 0, 4, 2, 0, 2, 4, 0};

  pmic_fault_event_latches #(.STARTUP_CYCLES(SC)) i_dut (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .analog_supply_low(supply_low), .buck_pg_event(ev[1:0]),
    .buck_enable(en[1:0]), .buck_below_min(low[1:0]),
    .buck_overcurrent(ev[3:2]), .boost_pg_event(ev[4]),
    .boost_enable(en[2]), .boost_below_min(low[2]),
    .boost_overcurrent(ev[5]), .monitor_pg_event(ev[7:6]),
    .analog_supply_pg_event(ev[8]), .clock_invalid(live_in[3]),
    .thermal_shutdown_status(live_in[2]),
    .thermal_warning_status(live_in[1]),
    .input_overvoltage_status(live_in[0]),
    .irq(irq), .converters_off(conv_off), .startup_go(go));

  // Clock generation
  always #2.5 clk = ~clk;

  // Tally of sequencing outputs seen at each edge
  always @(posedge clk) begin
    off_cnt += (conv_off === 1'b1);
    go_cnt  += (go === 1'b1);
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // One AHB-Lite single transfer; read data lands in rd
  // Waits on ready without a limit, only the watchdog ends a hang
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [7:0] d);
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    // Edges spent in the data phase, wait states included
    dp_edges = 0;
    do begin
      @(posedge clk);
      dp_edges++;
    end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp,
                       input string what);
    xfer(1'b0, idx, 8'h00);
    check(what, rd, exp);
  endtask

  // Rising edge on one event input, held long enough for the filter
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    repeat (4) @(posedge clk);
    ev[i] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic test_reset_values();
    logic [7:0] idx [10] = '{ev_pkg::IDX_SUMMARY, ev_pkg::IDX_RST,
      ev_pkg::IDX_BUCK, ev_pkg::IDX_BOOST, ev_pkg::IDX_MON,
      ev_pkg::IDX_LIVE, ev_pkg::IDX_MBUCK, ev_pkg::IDX_MBOOST,
      ev_pkg::IDX_MMON, ev_pkg::IDX_MRST};
    foreach (idx[i]) rdchk(idx[i], 32'h0, "reset value");
    check("read data phase edges", dp_edges, 2);
    check("irq after reset", irq, 1'b0);
    check("hresp", hresp, 1'b0);
    xfer(1'b1, ev_pkg::IDX_BUCK, 8'h88);
    check("write data phase edges", dp_edges, 2);
    rdchk(ev_pkg::IDX_BUCK, 32'h88, "reserved storage");
    xfer(1'b1, ev_pkg::IDX_BUCK, 8'h00);
    xfer(1'b1, ev_pkg::IDX_LIVE, 8'hFF);
    rdchk(ev_pkg::IDX_LIVE, 32'h0, "live write ignored");
    xfer(1'b1, 8'h3F, 8'hFF);
    rdchk(8'h3F, 32'h0, "unmapped read");
    xfer(1'b1, ev_pkg::IDX_MBUCK, 8'hFF);
    rdchk(ev_pkg::IDX_MBUCK, {24'h0, ev_pkg::BUCK_EVT}, "mask bits");
    xfer(1'b1, ev_pkg::IDX_MBUCK, 8'h00);
    // Remaining masks keep only their group's event bits
    xfer(1'b1, ev_pkg::IDX_MBOOST, 8'hFF);
    rdchk(ev_pkg::IDX_MBOOST, {24'h0, ev_pkg::BOOST_EVT}, "boost mask");
    xfer(1'b1, ev_pkg::IDX_MBOOST, 8'h00);
    xfer(1'b1, ev_pkg::IDX_MMON, 8'hFF);
    rdchk(ev_pkg::IDX_MMON, {24'h0, ev_pkg::MON_EVT}, "monitor mask");
    xfer(1'b1, ev_pkg::IDX_MMON, 8'h00);
    xfer(1'b1, ev_pkg::IDX_MRST, 8'hFF);
    rdchk(ev_pkg::IDX_MRST, {24'h0, ev_pkg::RST_EVT}, "reset mask");
    xfer(1'b1, ev_pkg::IDX_MRST, 8'h00);
    $display("test reset_values done");
  endtask

  task automatic test_live();
    for (int j = 0; j < 5; j++) begin
      live_in <= (j < 4) ? 4'h1 << j : 4'h0;
      repeat (5) @(posedge clk);
      rdchk(ev_pkg::IDX_LIVE, (j < 4) ? 1 << j : 0, "live status");
    end
    $display("test live done");
  endtask

  task automatic test_events();
    logic [7:0] sb;
    logic [7:0] b;
    for (int i = 0; i < 9; i++) begin
      sb = (EV_REG[i] == ev_pkg::IDX_BUCK) ? 8'h10 :
           (EV_REG[i] == ev_pkg::IDX_BOOST) ? 8'h20 : 8'h40;
      b = 8'h01 << EV_BIT[i];
      pulse(i);
      rdchk(EV_REG[i], {24'h0, b}, "flag");
      rdchk(ev_pkg::IDX_SUMMARY, {24'h0, sb}, "summary set");
      check("irq set", irq, 1'b1);
      xfer(1'b1, EV_REG[i], 8'h00);
      rdchk(EV_REG[i], {24'h0, b}, "flag kept on zero");
      xfer(1'b1, EV_REG[i], b);
      rdchk(EV_REG[i], 32'h0, "flag cleared");
      rdchk(ev_pkg::IDX_SUMMARY, 32'h0, "summary cleared");
      check("irq clear", irq, 1'b0);
    end
    $display("test events done");
  endtask

  task automatic test_mask();
    xfer(1'b1, ev_pkg::IDX_MBOOST, 8'h01);
    pulse(5);
    check("masked irq", irq, 1'b0);
    rdchk(ev_pkg::IDX_BOOST, 32'h1, "masked flag");
    xfer(1'b1, ev_pkg::IDX_MBOOST, 8'h00);
    check("unmasked irq", irq, 1'b1);
    xfer(1'b1, ev_pkg::IDX_BOOST, 8'h01);
    check("irq after clear", irq, 1'b0);
    $display("test mask done");
  endtask

  task automatic test_short();
    logic [7:0] r;
    logic [7:0] b;
    for (int k = 0; k < 3; k++) begin
      r = (k == 2) ? ev_pkg::IDX_BOOST : ev_pkg::IDX_BUCK;
      b = (k == 1) ? 8'h20 : 8'h02;
      low[k] <= 1'b1;
      en[k]  <= 1'b1;
      repeat (10) @(posedge clk);
      rdchk(r, 32'h0, "no short before timeout");
      repeat (SC) @(posedge clk);
      rdchk(r, {24'h0, b}, "start-up timeout");
      low[k] <= 1'b0;
      repeat (5) @(posedge clk);
      xfer(1'b1, r, b);
      rdchk(r, 32'h0, "short cleared");
      low[k] <= 1'b1;
      repeat (5) @(posedge clk);
      rdchk(r, {24'h0, b}, "short while running");
      low[k] <= 1'b0;
      en[k]  <= 1'b0;
      repeat (5) @(posedge clk);
      xfer(1'b1, r, b);
    end
    $display("test short done");
  endtask

  task automatic test_reset_event(input logic sw);
    int o0;
    int g0;
    xfer(1'b1, ev_pkg::IDX_BOOST, 8'h08);
    pulse(4);
    o0 = off_cnt;
    g0 = go_cnt;
    if (sw) begin
      xfer(1'b1, ev_pkg::IDX_SWRST, 8'h01);
    end else begin
      supply_low <= 1'b1;
    end
    repeat (14) @(posedge clk);
    supply_low <= 1'b0;
    check("converters off cycles", off_cnt - o0, 2);
    check("start-up pulses", go_cnt - g0, 1);
    rdchk(ev_pkg::IDX_BOOST, 32'h0, "registers reloaded");
    rdchk(ev_pkg::IDX_RST, 32'h1, "reset flag");
    check("irq on reset flag", irq, 1'b1);
    xfer(1'b1, ev_pkg::IDX_RST, 8'h00);
    rdchk(ev_pkg::IDX_RST, 32'h1, "reset flag kept");
    xfer(1'b1, ev_pkg::IDX_RST, 8'h01);
    rdchk(ev_pkg::IDX_RST, 32'h0, "reset flag cleared");
    rdchk(ev_pkg::IDX_SWRST, 32'h0, "software reset reads zero");
    $display("test reset_event done");
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    failures = 0;
    cmp_count = 0;
    off_cnt = 0;
    go_cnt = 0;
    resetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    supply_low = 1'b0;
    ev = 9'h000;
    en = 3'h0;
    low = 3'h0;
    live_in = 4'h0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    test_reset_values();
    test_live();
    test_events();
    test_mask();
    test_short();
    test_reset_event(1'b1);
    test_reset_event(1'b0);
    conclude();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule // pmic_fault_event_latches_bench
